// *** tbem_cfg.svh ***
/*
 Constants of the TDM bit error monitor: register indices, field
 positions, reset values, pattern taps and bus response codes.
 Assumes inclusion by bare name from every file that needs them.
*/
`ifndef TBEM_CFG_SVH
`define TBEM_CFG_SVH

// Register indices; byte address is four times the index
`define TBEM_IDX_LOC_SEL 8'h27
`define TBEM_IDX_LOC_CNT 8'h28
`define TBEM_IDX_BP_SEL 8'h29
`define TBEM_IDX_BP_CNT 8'h2a
`define TBEM_ADDR_LSB 2

// Selection register fields
`define TBEM_CHAN_LSB 0
`define TBEM_CHAN_MSB 7
`define TBEM_STREAM_LSB 8
`define TBEM_LOC_STREAM_MSB 11
`define TBEM_BP_STREAM_MSB 12
`define TBEM_LANE_LO 0
`define TBEM_LANE_HI 1

// Reset values
`define TBEM_SEL_STREAM_RST 5'h00
`define TBEM_SEL_CHAN_RST 8'h00
`define TBEM_CNT_RST 16'h0000

// Bits per channel as a shift, pattern taps (x^15 + x^14 + 1)
`define TBEM_CHAN_SHIFT 3
`define TBEM_PRBS_TAP_A 14
`define TBEM_PRBS_TAP_B 13

// Bus responses
`define TBEM_RESP_OKAY 2'h0
`define TBEM_RESP_SLVERR 2'h2

`endif

// *** tbem_pkg.sv ***
/*
 Types of the TDM bit error monitor.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package tbem_pkg;

  // One side of received serial traffic
  typedef struct packed {
    logic frame;
    logic bitStb;
    logic [31:0] data;
  } tbem_rx_t;

  // Stream and channel under test
  typedef struct packed {
    logic [4:0] stream;
    logic [7:0] channel;
  } tbem_sel_t;

  typedef enum {
    REG_NONE,
    REG_LOC_SEL,
    REG_LOC_CNT,
    REG_BP_SEL,
    REG_BP_CNT
  } tbem_reg_t;

endpackage

`default_nettype wire

// *** tbem_checker.sv ***
/*
 One bit error checker: picks a stream and channel out of the received
 traffic, compares each bit with a self-synchronising pattern and keeps
 a saturating error count.
 Assumes bitStb marks one received bit per stream and frame marks the
 first bit of a frame, both synchronous to ref_clk.
*/
`default_nettype none
`include "tbem_cfg.svh"

module tbem_checker #(
  parameter int SW = 5,
  parameter int CW = 16,
  parameter int PW = 15,
  parameter int IW = 11
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  input wire logic [SW-1:0] selStream,
  input wire logic [7:0] selChan,
  input wire tbem_pkg::tbem_rx_t rx,
  output logic [CW-1:0] errCnt
);

  logic [IW-1:0] bitCntR;
  logic [IW-1:0] bitIdx;
  logic [PW-1:0] shR;
  logic [4:0] fillR;
  logic hit;
  logic rxBit;
  logic expBit;
  logic err;

  assign bitIdx = rx.frame ? '0 : bitCntR;
  assign hit = rx.bitStb && (bitIdx[IW-1:`TBEM_CHAN_SHIFT] == selChan);
  assign rxBit = rx.data[selStream];
  assign expBit = shR[`TBEM_PRBS_TAP_A] ^ shR[`TBEM_PRBS_TAP_B];
  // Errors counted only once the pattern register is filled
  assign err = hit && (fillR == 5'(PW)) && (rxBit != expBit);

  // Bit position within the frame
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bitCntR <= '0;
    end else if (ce && rx.bitStb) begin
      bitCntR <= bitIdx + 1'b1;
    end
  end

  // Pattern register fed by the received bits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shR <= '0;
      fillR <= '0;
    end else if (ce) begin
      if (clr) begin
        fillR <= '0;
      end else if (hit && fillR != 5'(PW)) begin
        fillR <= fillR + 1'b1;
      end
      if (hit) begin
        shR <= {shR[PW-2:0], rxBit};
      end
    end
  end

  // Saturating count; an error in the clear cycle still counts
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      errCnt <= CW'(`TBEM_CNT_RST);
    end else if (ce) begin
      if (err && (clr || errCnt != '1)) begin
        errCnt <= clr ? CW'(1) : errCnt + 1'b1;
      end else if (clr) begin
        errCnt <= CW'(`TBEM_CNT_RST);
      end
    end
  end

  AST_COUNT_ON_MISMATCH: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && err && !clr && errCnt != '1) |=> errCnt == $past(errCnt) + 1'b1)
    else $error("mismatch not counted");

endmodule

`default_nettype wire

// *** tbem_top.sv ***
/*
 TDM bit error monitor with an AXI4-Lite register slave. Software picks
 a stream and channel on the local and the backplane side; each side has
 a checker with a 16-bit saturating error count.
 Assumes a single clock, synchronous inputs and AXI4-Lite masters that
 hold valid and payload until taken.
*/
`default_nettype none
`include "tbem_cfg.svh"

// How it works
// - Local select register holds a 4-bit local stream number in bits 11-8.
// - Local select register holds an 8-bit channel number in bits 7-0.
// - Local error count is 16 bits, readable, saturates at 0xffff.
// - Backplane select register holds a 5-bit stream number in bits 12-8.
// - Backplane select register holds an 8-bit channel number in bits 7-0.
// - Backplane error count is 16 bits, readable, saturates at 0xffff.
module tbem_top #(
  parameter int AW = 12,
  parameter int CW = 16,
  parameter int PW = 15,
  parameter int LOC_SW = 4,
  parameter int BP_SW = 5
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire tbem_pkg::tbem_rx_t locRx,
  input wire tbem_pkg::tbem_rx_t bpRx,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int XW = AW - `TBEM_ADDR_LSB;

  tbem_pkg::tbem_sel_t locSelR;
  tbem_pkg::tbem_sel_t bpSelR;
  tbem_pkg::tbem_reg_t wrReg;
  tbem_pkg::tbem_reg_t rdReg;
  logic [AW-1:0] awAddrR;
  logic [31:0] wDataR;
  logic [3:0] wStrbR;
  logic awGotR;
  logic wGotR;
  logic wrFire;
  logic wrOk;
  logic locClr;
  logic bpClr;
  logic [CW-1:0] locCnt;
  logic [CW-1:0] bpCnt;

  function automatic tbem_pkg::tbem_reg_t decode(input logic [AW-1:0] a);
    logic [XW-1:0] idx;
    idx = a[AW-1:`TBEM_ADDR_LSB];
    if (idx == XW'(`TBEM_IDX_LOC_SEL)) begin
      return tbem_pkg::REG_LOC_SEL;
    end else if (idx == XW'(`TBEM_IDX_LOC_CNT)) begin
      return tbem_pkg::REG_LOC_CNT;
    end else if (idx == XW'(`TBEM_IDX_BP_SEL)) begin
      return tbem_pkg::REG_BP_SEL;
    end else if (idx == XW'(`TBEM_IDX_BP_CNT)) begin
      return tbem_pkg::REG_BP_CNT;
    end
    return tbem_pkg::REG_NONE;
  endfunction

  assign wrReg = decode(awAddrR);
  assign rdReg = decode(s_axi_araddr);
  assign wrFire = awGotR && wGotR && !s_axi_bvalid;
  assign wrOk = (wrReg == tbem_pkg::REG_LOC_SEL) ||
                (wrReg == tbem_pkg::REG_BP_SEL);
  // A new selection restarts that side's count
  assign locClr = wrFire && wrReg == tbem_pkg::REG_LOC_SEL;
  assign bpClr = wrFire && wrReg == tbem_pkg::REG_BP_SEL;

  // Write address and data, taken in either order
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awGotR <= 1'b0;
      wGotR <= 1'b0;
      awAddrR <= '0;
      wDataR <= '0;
      wStrbR <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddrR <= s_axi_awaddr;
        awGotR <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDataR <= s_axi_wdata;
        wStrbR <= s_axi_wstrb;
        wGotR <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wrFire) begin
        awGotR <= 1'b0;
        wGotR <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TBEM_RESP_OKAY;
    end else if (ce) begin
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? `TBEM_RESP_OKAY : `TBEM_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Local selection; unused upper bits are not stored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      locSelR.stream <= `TBEM_SEL_STREAM_RST;
      locSelR.channel <= `TBEM_SEL_CHAN_RST;
    end else if (ce && locClr) begin
      if (wStrbR[`TBEM_LANE_LO]) begin
        locSelR.channel <= wDataR[`TBEM_CHAN_MSB:`TBEM_CHAN_LSB];
      end
      if (wStrbR[`TBEM_LANE_HI]) begin
        locSelR.stream <=
          5'(wDataR[`TBEM_LOC_STREAM_MSB:`TBEM_STREAM_LSB]);
      end
    end
  end

  // Backplane selection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bpSelR.stream <= `TBEM_SEL_STREAM_RST;
      bpSelR.channel <= `TBEM_SEL_CHAN_RST;
    end else if (ce && bpClr) begin
      if (wStrbR[`TBEM_LANE_LO]) begin
        bpSelR.channel <= wDataR[`TBEM_CHAN_MSB:`TBEM_CHAN_LSB];
      end
      if (wStrbR[`TBEM_LANE_HI]) begin
        bpSelR.stream <=
          wDataR[`TBEM_BP_STREAM_MSB:`TBEM_STREAM_LSB];
      end
    end
  end

  // Read channel: data one edge after the address is taken
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `TBEM_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `TBEM_RESP_OKAY;
        case (rdReg)
          tbem_pkg::REG_LOC_SEL: begin
            s_axi_rdata <= 32'({locSelR.stream, locSelR.channel});
          end
          tbem_pkg::REG_LOC_CNT: begin
            s_axi_rdata <= 32'(locCnt);
          end
          tbem_pkg::REG_BP_SEL: begin
            s_axi_rdata <= 32'({bpSelR.stream, bpSelR.channel});
          end
          tbem_pkg::REG_BP_CNT: begin
            s_axi_rdata <= 32'(bpCnt);
          end
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= `TBEM_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  tbem_checker #(
    .SW(LOC_SW),
    .CW(CW),
    .PW(PW)
  ) u_loc_chk (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .clr(locClr),
    .selStream(locSelR.stream[LOC_SW-1:0]),
    .selChan(locSelR.channel),
    .rx(locRx),
    .errCnt(locCnt)
  );

  tbem_checker #(
    .SW(BP_SW),
    .CW(CW),
    .PW(PW)
  ) u_bp_chk (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .clr(bpClr),
    .selStream(bpSelR.stream[BP_SW-1:0]),
    .selChan(bpSelR.channel),
    .rx(bpRx),
    .errCnt(bpCnt)
  );

  AST_LOC_STREAM_WRITE: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && locClr && wStrbR[`TBEM_LANE_HI])
    |=> locSelR.stream ==
        5'($past(wDataR[`TBEM_LOC_STREAM_MSB:`TBEM_STREAM_LSB])))
    else $error("local stream field not loaded");

  AST_LOC_CHAN_WRITE: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && locClr && wStrbR[`TBEM_LANE_LO])
    |=> locSelR.channel == $past(wDataR[`TBEM_CHAN_MSB:`TBEM_CHAN_LSB]))
    else $error("local channel field not loaded");

  AST_LOC_SEL_READ: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && s_axi_arvalid && s_axi_arready &&
     rdReg == tbem_pkg::REG_LOC_SEL)
    |=> s_axi_rvalid && (s_axi_rdata >> (`TBEM_LOC_STREAM_MSB + 1)) == '0 &&
        s_axi_rdata[`TBEM_CHAN_MSB:`TBEM_CHAN_LSB] == $past(locSelR.channel))
    else $error("local select read wrong");

  AST_LOC_SATURATE: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && locCnt == '1 && !locClr) |=> locCnt == '1)
    else $error("local count left its maximum");

  AST_LOC_NO_WRAP: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && !locClr) |=> (locCnt == $past(locCnt)) ||
      ($past(locCnt) != '1 && locCnt == $past(locCnt) + 1'b1))
    else $error("local count jumped or wrapped");

  AST_LOC_READ: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && s_axi_arvalid && s_axi_arready &&
     rdReg == tbem_pkg::REG_LOC_CNT)
    |=> s_axi_rvalid && s_axi_rdata == 32'($past(locCnt)))
    else $error("local count read wrong");

  AST_BP_STREAM_WRITE: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && bpClr && wStrbR[`TBEM_LANE_HI])
    |=> bpSelR.stream ==
        $past(wDataR[`TBEM_BP_STREAM_MSB:`TBEM_STREAM_LSB]))
    else $error("backplane stream field not loaded");

  AST_BP_CHAN_WRITE: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && bpClr && wStrbR[`TBEM_LANE_LO])
    |=> bpSelR.channel == $past(wDataR[`TBEM_CHAN_MSB:`TBEM_CHAN_LSB]))
    else $error("backplane channel field not loaded");

  AST_BP_SEL_READ: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && s_axi_arvalid && s_axi_arready &&
     rdReg == tbem_pkg::REG_BP_SEL)
    |=> s_axi_rvalid && (s_axi_rdata >> (`TBEM_BP_STREAM_MSB + 1)) == '0 &&
        s_axi_rdata[`TBEM_CHAN_MSB:`TBEM_CHAN_LSB] == $past(bpSelR.channel))
    else $error("backplane select read wrong");

  AST_BP_SATURATE: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && bpCnt == '1 && !bpClr) |=> bpCnt == '1)
    else $error("backplane count left its maximum");

  AST_BP_NO_WRAP: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && !bpClr) |=> (bpCnt == $past(bpCnt)) ||
      ($past(bpCnt) != '1 && bpCnt == $past(bpCnt) + 1'b1))
    else $error("backplane count jumped or wrapped");

  AST_BP_READ: assert property (@(posedge ref_clk)
    disable iff (rst)
    (ce && s_axi_arvalid && s_axi_arready &&
     rdReg == tbem_pkg::REG_BP_CNT)
    |=> s_axi_rvalid && s_axi_rdata == 32'($past(bpCnt)))
    else $error("backplane count read wrong");

endmodule

`default_nettype wire

// *** tbem_tdm_src.sv ***
/*
 Serial traffic source for one side of the monitor: PRBS bits in the
 chosen stream and channel, random bits elsewhere, rare flipped bits,
 and its own count of the errors a checker must report.
 Assumes ref_clk, rst and ce shared with the monitor; restart and
 selection changes only while run is low.
*/
`default_nettype none

module tbem_tdm_src (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  input wire logic restart,
  input wire logic allOnes,
  input wire logic [4:0] selStream,
  input wire logic [7:0] selChan,
  output var tbem_pkg::tbem_rx_t rx,
  output var logic [15:0] expCnt
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 91384;
  int fill = 0;
  logic [14:0] gen = 15'h7fff;
  logic [14:0] rcv;
  logic [4:0] idx = 5'h00;
  logic [31:0] d;
  logic b;
  logic sel = 1'h0;

  initial rx = '0;
  initial expCnt = 16'h0000;

  always @(posedge ref_clk) begin
    if (rst) idx = 5'h00;
    if (rst || restart) begin
      fill = 0;
      expCnt = 16'h0000;
    end else if (ce && rx.bitStb) begin
      if (sel) begin
        b = rx.data[selStream];
        // Self-synchronising compare after a 15-bit fill
        if (fill >= 15 && b !== (rcv[14] ^ rcv[13]) &&
            expCnt != 16'hffff) expCnt = expCnt + 16'h0001;
        if (fill < 15) fill++;
        rcv = {rcv[13:0], b};
        gen = {gen[13:0], gen[14] ^ gen[13]};
      end
      idx = rx.frame ? 5'h01 : idx + 5'h01;
    end
    // Every bit a frame start in saturation mode: channel 0 only
    sel = selChan == (allOnes ? 8'h00 : {6'h00, idx[4:3]});
    b = allOnes | (gen[14] ^ gen[13] ^ ($random(seed) % 16 == 0));
    d = $random(seed);
    if (sel) d[selStream] = b;
    rx.data <= d;
    rx.frame <= allOnes || idx == 5'h00;
    rx.bitStb <= run && (allOnes || $random(seed) % 4 != 0);
  end
endmodule

`default_nettype wire

// *** tdm_bit_error_monitor_tb.sv ***
/*
 Self-checking bench of the bit error monitor: register map, refused
 accesses, counting against the PRBS sources, saturation.
 Assumes the design files and tbem_tdm_src are compiled first.
*/
`default_nettype none
`include "tbem_cfg.svh"

module tdm_bit_error_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] A_LS = 12'(`TBEM_IDX_LOC_SEL) << `TBEM_ADDR_LSB;
  localparam logic [11:0] A_LC = 12'(`TBEM_IDX_LOC_CNT) << `TBEM_ADDR_LSB;
  localparam logic [11:0] A_BS = 12'(`TBEM_IDX_BP_SEL) << `TBEM_ADDR_LSB;
  localparam logic [11:0] A_BC = 12'(`TBEM_IDX_BP_CNT) << `TBEM_ADDR_LSB;
  localparam logic [11:0] A_UN = 12'hffc;
  localparam logic [1:0] OK = `TBEM_RESP_OKAY;
  localparam logic [1:0] SE = `TBEM_RESP_SLVERR;
  logic ref_clk = 1'h0, rst = 1'h1, ce = 1'h1;
  logic run = 1'h0, rsta = 1'h0, ones = 1'h0;
  tbem_pkg::tbem_rx_t locRx, bpRx;
  logic [4:0] ls = 5'h00, bs = 5'h00;
  logic [7:0] lc = 8'h00, bc = 8'h00;
  logic [15:0] le, be;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  int seed = 91384;
  int errCount = 0;
  int checkCount = 0;
  logic [33:0] q[$];
  logic [33:0] e;
  logic [1:0] qb[$];
  logic [1:0] eb;
  logic [3:0] strb = 4'hf;

  initial forever #50 ref_clk = ~ref_clk;

  tbem_top i_dut (.ref_clk, .rst, .ce, .locRx, .bpRx,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  tbem_tdm_src i_loc (.ref_clk, .rst, .ce, .run, .restart(rsta),
    .allOnes(ones), .selStream(ls), .selChan(lc), .rx(locRx),
    .expCnt(le));
  tbem_tdm_src i_bp (.ref_clk, .rst, .ce, .run, .restart(rsta),
    .allOnes(ones), .selStream(bs), .selChan(bc), .rx(bpRx),
    .expCnt(be));

  task automatic bad(input string w, input logic [33:0] x, y);
    $display("BAD %s exp %h got %h", w, x, y);
    errCount++;
  endtask

  task automatic testDone;
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    qb.push_back(er);
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'h0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    s_axi_bready <= 1'h0;
    if (n == 40) begin
      bad("bvalid", 34'h1, 34'h0);
      testDone;
    end
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] x);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    q.push_back(x);
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    s_axi_rready <= 1'h0;
    if (n == 40) begin
      bad("rvalid", 34'h1, 34'h0);
      testDone;
    end
    @(posedge ref_clk);
  endtask

  // Bus answers checked against the oldest note
  always @(posedge ref_clk) begin
    if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1) begin
      checkCount++;
      eb = qb.size() > 0 ? qb.pop_front() : 2'h3;
      if (s_axi_bresp !== eb)
        bad("bresp", 34'(eb), 34'(s_axi_bresp));
    end
    if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) begin
      checkCount++;
      e = q.size() > 0 ? q.pop_front() : 34'h3ffffffff;
      if ({s_axi_rresp, s_axi_rdata} !== e)
        bad("rdata", e, {s_axi_rresp, s_axi_rdata});
    end
  end

  task automatic setSel;
    wr(A_LS, {16'h0000, 4'h0, ls[3:0], lc}, OK);
    wr(A_BS, {19'h0, bs, bc}, OK);
    rsta <= 1'h1;
    @(posedge ref_clk);
    rsta <= 1'h0;
    rd(A_LS, {OK, 20'h0, ls[3:0], lc});
    rd(A_BS, {OK, 19'h0, bs, bc});
  endtask

  task automatic traffic(input int n, input logic rc);
    run <= 1'h1;
    repeat (n) begin
      ce <= rc ? $random(seed) % 4 != 0 : 1'h1;
      @(posedge ref_clk);
    end
    run <= 1'h0;
    ce <= 1'h1;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic rdCnt;
    rd(A_LC, {OK, 16'h0, le});
    rd(A_BC, {OK, 16'h0, be});
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    rd(A_LS, {OK, 32'h0});
    rd(A_BS, {OK, 32'h0});
    rdCnt;
    rd(A_UN, {SE, 32'h0});
    wr(A_UN, 32'h1, SE);
    $display("test reset and map done");
    strb = 4'h2;
    wr(A_LS, 32'h00000a55, OK);
    rd(A_LS, {OK, 32'h00000a00});
    strb = 4'h1;
    wr(A_BS, 32'h00001f33, OK);
    rd(A_BS, {OK, 32'h00000033});
    strb = 4'hf;
    $display("test byte lanes done");
    for (int i = 0; i < 4; i++) begin
      ls <= 5'($random(seed) & 15);
      lc <= 8'($random(seed) & 3);
      bs <= 5'($random(seed));
      bc <= 8'($random(seed) & 3);
      @(posedge ref_clk);
      setSel;
      traffic(800, 1'h1);
      rdCnt;
      wr(A_LC, 32'hffff, SE);
      wr(A_BC, 32'hffff, SE);
      rdCnt;
      $display("test traffic %0d done", i);
    end
    ones <= 1'h1;
    lc <= 8'h00;
    bc <= 8'h00;
    @(posedge ref_clk);
    setSel;
    traffic(65600, 1'h0);
    rd(A_LC, {OK, 32'h0000ffff});
    rd(A_BC, {OK, 32'h0000ffff});
    $display("test saturation done");
    testDone;
  end
endmodule

`default_nettype wire
